// [prio_pkg.sv]
// constants for the interrupt priority field bank
package prio_pkg;
    localparam int          ADDR_W          = 12;
    localparam int          FIELD_W         = 3;
    localparam int          NUM_FIELDS      = 20;
    // byte offsets of the priority registers
    localparam logic [11:0] OFF_SEVEN       = 12'h000;
    localparam logic [11:0] OFF_EIGHT       = 12'h004;
    localparam logic [11:0] OFF_NINE        = 12'h008;
    localparam logic [11:0] OFF_TWELVE      = 12'h00c;
    localparam logic [11:0] OFF_THIRTEEN    = 12'h010;
    localparam logic [11:0] OFF_FOURTEEN    = 12'h014;
    localparam logic [11:0] OFF_SIXTEEN     = 12'h018;
    localparam logic [11:0] OFF_SEVENTEEN   = 12'h01c;
    // field low-bit positions within a 16-bit register
    localparam int          POS_HI          = 12;
    localparam int          POS_MH          = 8;
    localparam int          POS_ML          = 4;
    localparam int          POS_LO          = 0;
    localparam logic [2:0]  LEVEL_RESET     = 3'h4;
    localparam logic [2:0]  LEVEL_OFF       = 3'h0;
endpackage : prio_pkg

// [prio_field.sv]
// one 3-bit writable priority field with power-on level
`timescale 1ns/10ps
module prio_field #(
    parameter int POS = 0
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        wr,
    input  wire logic [15:0] wdata,
    output logic [2:0]       level
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level <= prio_pkg::LEVEL_RESET;
        end else if (wr) begin
            level <= wdata[POS +: prio_pkg::FIELD_W];
        end
    end
endmodule : prio_field

// [prio_bank.sv]
// bank of interrupt priority configuration registers on apb
// What this block does
// - 3-bit level per source: 7 highest, 1 lowest, 0 disables source.
// - seventh register: serial2 tx, serial2 rx, ext pin 2, timer 5.
// - eighth register: can event, can rx ready, spi2 event, spi2 error.
// - sixteenth register: serial2 error 10:8, serial1 error 6:4 only.
// - every field resets to level 4: top bit set, others clear.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module prio_bank #(
    parameter bit HAS_CAN = 1'b1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [2:0]       second_serial_tx_level,
    output logic [2:0]       second_serial_rx_level,
    output logic [2:0]       ext_pin2_level,
    output logic [2:0]       timer5_level,
    output logic [2:0]       can_event_level,
    output logic [2:0]       can_rx_ready_level,
    output logic [2:0]       second_spi_event_level,
    output logic [2:0]       second_spi_error_level,
    output logic [2:0]       capture4_level,
    output logic [2:0]       capture3_level,
    output logic [2:0]       dma_ch3_done_level,
    output logic [2:0]       second_i2c_master_level,
    output logic [2:0]       second_i2c_slave_level,
    output logic [2:0]       ext_pin4_level,
    output logic [2:0]       ext_pin3_level,
    output logic [2:0]       encoder1_level,
    output logic [2:0]       pwm_special_match_level,
    output logic [2:0]       second_serial_error_level,
    output logic [2:0]       first_serial_error_level,
    output logic [2:0]       can_tx_request_level
);
    localparam int N = prio_pkg::NUM_FIELDS;

    // field table in output order: register holding each field
    localparam logic [11:0] FOFF [N] = '{
        prio_pkg::OFF_SEVEN,
        prio_pkg::OFF_SEVEN,
        prio_pkg::OFF_SEVEN,
        prio_pkg::OFF_SEVEN,
        prio_pkg::OFF_EIGHT,
        prio_pkg::OFF_EIGHT,
        prio_pkg::OFF_EIGHT,
        prio_pkg::OFF_EIGHT,
        prio_pkg::OFF_NINE,
        prio_pkg::OFF_NINE,
        prio_pkg::OFF_NINE,
        prio_pkg::OFF_TWELVE,
        prio_pkg::OFF_TWELVE,
        prio_pkg::OFF_THIRTEEN,
        prio_pkg::OFF_THIRTEEN,
        prio_pkg::OFF_FOURTEEN,
        prio_pkg::OFF_FOURTEEN,
        prio_pkg::OFF_SIXTEEN,
        prio_pkg::OFF_SIXTEEN,
        prio_pkg::OFF_SEVENTEEN
    };

    // low bit of each field, same order
    localparam int FPOS [N] = '{
        prio_pkg::POS_HI,
        prio_pkg::POS_MH,
        prio_pkg::POS_ML,
        prio_pkg::POS_LO,
        prio_pkg::POS_HI,
        prio_pkg::POS_MH,
        prio_pkg::POS_ML,
        prio_pkg::POS_LO,
        prio_pkg::POS_MH,
        prio_pkg::POS_ML,
        prio_pkg::POS_LO,
        prio_pkg::POS_MH,
        prio_pkg::POS_ML,
        prio_pkg::POS_MH,
        prio_pkg::POS_ML,
        prio_pkg::POS_MH,
        prio_pkg::POS_ML,
        prio_pkg::POS_MH,
        prio_pkg::POS_ML,
        prio_pkg::POS_MH
    };

    // one field's worth of ones, and that mask at each field position
    localparam logic [15:0] FIELD_ONES = 16'((1 << prio_pkg::FIELD_W) - 1);
    localparam logic [15:0] M_HI       = FIELD_ONES << prio_pkg::POS_HI;
    localparam logic [15:0] M_MH       = FIELD_ONES << prio_pkg::POS_MH;
    localparam logic [15:0] M_ML       = FIELD_ONES << prio_pkg::POS_ML;
    localparam logic [15:0] M_LO       = FIELD_ONES << prio_pkg::POS_LO;

    // implemented bits of the four register layouts in the bank
    localparam logic [15:0] MASK_FULL  = M_HI | M_MH | M_ML | M_LO;
    localparam logic [15:0] MASK_LOW3  = M_MH | M_ML | M_LO;
    localparam logic [15:0] MASK_MID2  = M_MH | M_ML;
    localparam logic [15:0] MASK_MID1  = M_MH;

    logic [2:0]   lvl [N];
    logic [15:0]  rd_word [N];
    logic [N-1:0] fwr;
    logic [15:0]  impl_mask;

    // apb phases
    wire access   = psel && penable;
    wire setup_rd = psel && !penable && !pwrite;
    // a register spans two byte lanes, so a write needs both strobes
    wire lanes_ok = pstrb[0] && pstrb[1];
    wire wr_en    = access && pwrite && lanes_ok;

    // implemented bits of the addressed register
    always_comb begin
        if (paddr == prio_pkg::OFF_SEVEN) begin
            impl_mask = MASK_FULL;
        end else if (paddr == prio_pkg::OFF_EIGHT) begin
            impl_mask = MASK_FULL;
        end else if (paddr == prio_pkg::OFF_NINE) begin
            impl_mask = MASK_LOW3;
        end else if (paddr == prio_pkg::OFF_TWELVE) begin
            impl_mask = MASK_MID2;
        end else if (paddr == prio_pkg::OFF_THIRTEEN) begin
            impl_mask = MASK_MID2;
        end else if (paddr == prio_pkg::OFF_FOURTEEN) begin
            impl_mask = MASK_MID2;
        end else if (paddr == prio_pkg::OFF_SIXTEEN) begin
            impl_mask = MASK_MID2;
        end else if (paddr == prio_pkg::OFF_SEVENTEEN) begin
            impl_mask = MASK_MID1;
        end else begin
            impl_mask = 16'h0000;
        end
    end

    // unmapped offsets answer with an error; every mapped one has a field
    wire hit = (impl_mask != 16'h0000);

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_field
            assign fwr[g] = wr_en && (paddr == FOFF[g]);
            // each field wakes at level four
            prio_field #(.POS(FPOS[g])) u_field (
                .pclk    (pclk),
                .presetn (presetn),
                .wr      (fwr[g]),
                .wdata   (pwdata[15:0]),
                .level   (lvl[g])
            );
            // only field bits reach the read word
            assign rd_word[g] = (paddr == FOFF[g])
                ? (16'(lvl[g]) << FPOS[g]) : 16'h0000;
        end
    endgenerate

    // only fields of the addressed register are non-zero, so or acts as mux
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        for (int i = 0; i < N; i++) begin
            rd_mux = rd_mux | rd_word[i];
        end
    end

    // zero-wait slave: every access ends in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = access && !hit;

    // read word captured at the end of setup, so it stands through the
    // whole access phase; costs one flop per data bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_rd) begin
            // gaps masked again in case the field table is edited
            prdata <= {16'h0000, rd_mux & impl_mask};
        end
    end

    // levels go out unchanged; zero means disabled downstream
    assign second_serial_tx_level    = lvl[0];
    assign second_serial_rx_level    = lvl[1];
    assign ext_pin2_level            = lvl[2];
    assign timer5_level              = lvl[3];

    // can levels forced off when HAS_CAN is clear; the fields still read back
    assign can_event_level    = HAS_CAN ? lvl[4] : prio_pkg::LEVEL_OFF;
    assign can_rx_ready_level = HAS_CAN ? lvl[5] : prio_pkg::LEVEL_OFF;
    // spi2 fields of the eighth register
    assign second_spi_event_level    = lvl[6];
    assign second_spi_error_level    = lvl[7];

    // ninth register
    assign capture4_level            = lvl[8];
    assign capture3_level            = lvl[9];
    assign dma_ch3_done_level        = lvl[10];

    // twelfth register
    assign second_i2c_master_level   = lvl[11];
    assign second_i2c_slave_level    = lvl[12];

    // thirteenth register
    assign ext_pin4_level            = lvl[13];
    assign ext_pin3_level            = lvl[14];

    // fourteenth register
    assign encoder1_level            = lvl[15];
    assign pwm_special_match_level   = lvl[16];

    assign second_serial_error_level = lvl[17];
    assign first_serial_error_level  = lvl[18];

    assign can_tx_request_level = HAS_CAN ? lvl[19] : prio_pkg::LEVEL_OFF;
endmodule : prio_bank

// [prio_bank_asserts.sv]
// port-level assertions for the priority bank
`timescale 1ns/10ps
module prio_bank_asserts #(parameter bit HAS_CAN = 1'b1) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic [2:0]  timer5_level,
    input wire logic [2:0]  second_serial_tx_level,
    input wire logic [2:0]  can_rx_ready_level,
    input wire logic [2:0]  first_serial_error_level,
    input wire logic [2:0]  encoder1_level
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire        wr = psel && penable && pwrite && pready && &pstrb[1:0];
    logic [15:0] wd;
    always_ff @(posedge pclk) wd <= pwdata[15:0];
    a_level_write: assert property (wr && paddr == 12'h000 |=>
        timer5_level == wd[2:0]) else $error("timer5 level wrong");
    a_tx_field: assert property (wr && paddr == 12'h000 |=>
        second_serial_tx_level == wd[14:12]) else $error("tx level wrong");
    a_can_rx_field: assert property (wr && paddr == 12'h004 |=>
        can_rx_ready_level == (HAS_CAN ? wd[10:8] : 3'h0))
        else $error("can rx level wrong");
    a_no_can: assert property (!HAS_CAN |->
        can_rx_ready_level == 3'h0) else $error("can level raised");
    a_err_field: assert property (wr && paddr == 12'h018 |=>
        first_serial_error_level == wd[6:4]) else $error("err level wrong");
    a_reset_level: assert property ($rose(presetn) |->
        timer5_level == 3'h4 && encoder1_level == 3'h4)
        else $error("reset level wrong");
    a_gap_zero: assert property (psel && penable && !pwrite |->
        prdata[31:15] == 17'h0 && !prdata[11] && !prdata[7] && !prdata[3])
        else $error("gap bit set");
endmodule : prio_bank_asserts
bind prio_bank prio_bank_asserts #(.HAS_CAN(HAS_CAN)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .timer5_level(timer5_level),
    .second_serial_tx_level(second_serial_tx_level),
    .can_rx_ready_level(can_rx_ready_level),
    .first_serial_error_level(first_serial_error_level),
    .encoder1_level(encoder1_level)
);

// [testbench.sv]
// self-checking bench for the priority bank
`timescale 1ns/10ps
module testbench;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hf;
    logic [2:0]  second_serial_tx_level, second_serial_rx_level,
        ext_pin2_level, timer5_level, can_event_level, can_rx_ready_level,
        second_spi_event_level, second_spi_error_level, capture4_level,
        capture3_level, dma_ch3_done_level, second_i2c_master_level,
        second_i2c_slave_level, ext_pin4_level, ext_pin3_level,
        encoder1_level, pwm_special_match_level, second_serial_error_level,
        first_serial_error_level, can_tx_request_level;
    logic [2:0]  nc_event, nc_rx, nc_tx;
    logic [15:0] rv [8] = '{16'h4444, 16'h4444, 16'h0444, 16'h0440,
        16'h0440, 16'h0440, 16'h0440, 16'h0400};
    int          fail_count = 0, tests_run = 0;
    prio_bank dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .second_serial_tx_level(second_serial_tx_level),
        .second_serial_rx_level(second_serial_rx_level),
        .ext_pin2_level(ext_pin2_level), .timer5_level(timer5_level),
        .can_event_level(can_event_level),
        .can_rx_ready_level(can_rx_ready_level),
        .second_spi_event_level(second_spi_event_level),
        .second_spi_error_level(second_spi_error_level),
        .capture4_level(capture4_level), .capture3_level(capture3_level),
        .dma_ch3_done_level(dma_ch3_done_level),
        .second_i2c_master_level(second_i2c_master_level),
        .second_i2c_slave_level(second_i2c_slave_level),
        .ext_pin4_level(ext_pin4_level), .ext_pin3_level(ext_pin3_level),
        .encoder1_level(encoder1_level),
        .pwm_special_match_level(pwm_special_match_level),
        .second_serial_error_level(second_serial_error_level),
        .first_serial_error_level(first_serial_error_level),
        .can_tx_request_level(can_tx_request_level)
    );
    // same bus, variant without the can controller
    prio_bank #(.HAS_CAN(1'b0)) nocan_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(), .pready(), .pslverr(),
        .second_serial_tx_level(), .second_serial_rx_level(),
        .ext_pin2_level(), .timer5_level(),
        .can_event_level(nc_event), .can_rx_ready_level(nc_rx),
        .second_spi_event_level(), .second_spi_error_level(),
        .capture4_level(), .capture3_level(), .dma_ch3_done_level(),
        .second_i2c_master_level(), .second_i2c_slave_level(),
        .ext_pin4_level(), .ext_pin3_level(), .encoder1_level(),
        .pwm_special_match_level(), .second_serial_error_level(),
        .first_serial_error_level(), .can_tx_request_level(nc_tx)
    );
    always #5 pclk = ~pclk;
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic t_regs;
        for (int i = 0; i < 8; i++) begin
            xfer(1'b0, 12'(4 * i), 32'h0);
            check(rd, {16'h0, rv[i]});
            xfer(1'b1, 12'(4 * i), 32'hffffffff);
            xfer(1'b0, 12'(4 * i), 32'h0);
            check(rd, {16'h0, rv[i] | rv[i] >> 1 | rv[i] >> 2});
        end
        xfer(1'b0, 12'h020, 32'h0);
        check(32'(er), 32'h1);
        check(rd, 32'h0);
        $display("register map test done");
    endtask : t_regs
    task automatic t_fields;
        xfer(1'b1, 12'h000, 32'h7130);
        @(negedge pclk);
        check({second_serial_tx_level, second_serial_rx_level, ext_pin2_level,
            timer5_level}, {3'h7, 3'h1, 3'h3, 3'h0});
        check(32'(timer5_level), 32'h0);
        xfer(1'b1, 12'h004, 32'h1706);
        @(negedge pclk);
        check({can_event_level, can_rx_ready_level, second_spi_event_level,
            second_spi_error_level}, {3'h1, 3'h7, 3'h0, 3'h6});
        check({nc_event, nc_rx}, 32'h0);
        xfer(1'b1, 12'h008, 32'h0352);
        @(negedge pclk);
        check({capture4_level, capture3_level, dma_ch3_done_level},
            {3'h3, 3'h5, 3'h2});
        xfer(1'b1, 12'h00c, 32'h0610);
        @(negedge pclk);
        check({second_i2c_master_level, second_i2c_slave_level},
            {3'h6, 3'h1});
        xfer(1'b1, 12'h010, 32'h0270);
        @(negedge pclk);
        check({ext_pin4_level, ext_pin3_level}, {3'h2, 3'h7});
        xfer(1'b1, 12'h014, 32'h0160);
        @(negedge pclk);
        check({encoder1_level, pwm_special_match_level}, {3'h1, 3'h6});
        xfer(1'b1, 12'h018, 32'h0520);
        @(negedge pclk);
        check({second_serial_error_level, first_serial_error_level},
            {3'h5, 3'h2});
        xfer(1'b1, 12'h01c, 32'h0300);
        @(negedge pclk);
        check({can_tx_request_level, nc_tx}, {3'h3, 3'h0});
        $display("field mapping test done");
    endtask : t_fields
    task automatic t_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check(32'(timer5_level), 32'h4);
        xfer(1'b0, 12'h000, 32'h0);
        check(rd, {16'h0, rv[0]});
        $display("mid-run reset test done");
    endtask : t_reset
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_fields();
        t_reset();
        conclude();
    end
    // about 100 transfer cycles expected
    initial begin
        #20000;
        fail_count++;
        conclude();
    end
endmodule : testbench
